// >>> verilog/qdac_device.sv
// converter end: serial frame capture, holding and active code registers
// Summary of operation
// - frame select low shifts data on falling edges
// - host never lowers select on falling edge
// - sixteenth falling edge captures and executes command
// - edges after sixteenth ignored until new frame
// - host raises select high for one half period before each frame
// - host idles select and data low
// - first two bits address channel A to D
// - next two bits choose one of four operations
// - last twelve bits are code, MSB first
// - each channel code ranges 0 to 4095
// - early select rise discards the whole frame
// - power-up clears codes, outputs held at zero
// - op 11 powers down, address picks termination
// - 00/11 high-Z, 01 2.5k, 10 100k
// - power-down keeps channel codes unchanged
`timescale 1ns/100ps
`default_nettype none
module qdac_device #(
  parameter int CHANNELS = qdac_pkg::CHANNELS,
  parameter int CODE_BITS = qdac_pkg::CODE_BITS
) (
  // power-on reset
  input wire logic resetn,
  // serial link
  qdac_link_if.device link,
  // converter side
  output logic [CHANNELS*CODE_BITS-1:0] active_code,
  output logic powered_down,
  output logic [1:0] termination,
  output logic frame_done
);
  logic [qdac_pkg::FRAME_BITS-2:0] shift_q;
  logic [4:0] count_q;
  logic [CODE_BITS-1:0] hold_q [CHANNELS];
  logic [CODE_BITS-1:0] act_q [CHANNELS];
  logic pd_q;
  logic [1:0] term_q;
  logic done_q;
  logic [qdac_pkg::FRAME_BITS-1:0] word;
  logic last_edge;
  logic [1:0] addr;
  logic [1:0] op;
  logic [CODE_BITS-1:0] code;
  logic frame_rst_n;

  // select high clears the bit count asynchronously, so an early rise
  // discards the partial frame without needing any link clock edge
  assign frame_rst_n = resetn & ~link.frame_n;
  assign word = {shift_q, link.sdata};
  assign last_edge = (count_q == 5'(qdac_pkg::FRAME_BITS - 1));
  assign addr = word[qdac_pkg::ADDR_MSB:qdac_pkg::ADDR_LSB];
  assign op = word[qdac_pkg::OP_MSB:qdac_pkg::OP_LSB];
  assign code = word[CODE_BITS-1:0];

  // link sampled on falling edges while selected
  always_ff @(negedge link.sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      count_q <= qdac_pkg::BIT_COUNT_RESET;
      shift_q <= '0;
    end else if (count_q < 5'(qdac_pkg::FRAME_BITS)) begin
      shift_q <= word[qdac_pkg::FRAME_BITS-2:0];
      count_q <= count_q + 5'h01;
    end
  end

  // holding registers only change on a complete frame
  always_ff @(negedge link.sclk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < CHANNELS; i++) hold_q[i] <= qdac_pkg::CODE_RESET;
    end else if (!link.frame_n && last_edge) begin
      unique case (op)
        qdac_pkg::OP_LOAD_ONLY, qdac_pkg::OP_LOAD_UPDATE: hold_q[addr] <= code;
        qdac_pkg::OP_LOAD_ALL: begin
          for (int i = 0; i < CHANNELS; i++) hold_q[i] <= code;
        end
        qdac_pkg::OP_POWER_DOWN: ;
      endcase
    end
  end

  // active registers copy all holding values at once on update
  always_ff @(negedge link.sclk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < CHANNELS; i++) act_q[i] <= qdac_pkg::CODE_RESET;
    end else if (!link.frame_n && last_edge) begin
      if (op == qdac_pkg::OP_LOAD_UPDATE) begin
        for (int i = 0; i < CHANNELS; i++) begin
          act_q[i] <= (i == int'(addr)) ? code : hold_q[i];
        end
      end else if (op == qdac_pkg::OP_LOAD_ALL) begin
        for (int i = 0; i < CHANNELS; i++) act_q[i] <= code;
      end
    end
  end

  // power state: any non-power-down frame wakes the outputs
  always_ff @(negedge link.sclk or negedge resetn) begin
    if (!resetn) begin
      pd_q <= 1'b0;
      term_q <= qdac_pkg::TERM_HIZ_A;
    end else if (!link.frame_n && last_edge) begin
      pd_q <= (op == qdac_pkg::OP_POWER_DOWN);
      if (op == qdac_pkg::OP_POWER_DOWN) term_q <= addr;
    end
  end

  // marker of an executed frame, held until the next link clock fall
  always_ff @(negedge link.sclk or negedge resetn) begin
    if (!resetn) done_q <= 1'b0;
    else done_q <= !link.frame_n && last_edge;
  end

  // codes span 0..4095 by width alone
  for (genvar g = 0; g < CHANNELS; g++) begin : g_out
    assign active_code[g*CODE_BITS +: CODE_BITS] = act_q[g];
  end
  assign powered_down = pd_q;
  assign termination = term_q;
  assign frame_done = done_q;
endmodule : qdac_device
`default_nettype wire

// >>> include/qdac_pkg.sv
// shared constants for the quad converter serial write link
package qdac_pkg;
  localparam int FRAME_BITS = 16;
  localparam int CODE_BITS = 12;
  localparam int CHANNELS = 4;
  localparam int ADDR_MSB = 15;
  localparam int ADDR_LSB = 14;
  localparam int OP_MSB = 13;
  localparam int OP_LSB = 12;
  localparam logic [1:0] OP_LOAD_ONLY = 2'h0;
  localparam logic [1:0] OP_LOAD_UPDATE = 2'h1;
  localparam logic [1:0] OP_LOAD_ALL = 2'h2;
  localparam logic [1:0] OP_POWER_DOWN = 2'h3;
  localparam logic [1:0] TERM_HIZ_A = 2'h0;
  localparam logic [1:0] TERM_2K5 = 2'h1;
  localparam logic [1:0] TERM_100K = 2'h2;
  localparam logic [1:0] TERM_HIZ_B = 2'h3;
  localparam logic [11:0] CODE_RESET = 12'h000;
  localparam logic [4:0] BIT_COUNT_RESET = 5'h00;
  // least frame select high time between frames
  localparam int SELECT_HIGH_NS = 10;
  localparam int SYS_PERIOD_NS = 8;
  localparam int SELECT_HIGH_CYC = (SELECT_HIGH_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  // host link clock divider: half period in system cycles
  localparam int LINK_HALF_CYC = 3;
endpackage : qdac_pkg

// >>> include/qdac_link_if.sv
// three-wire serial write link between host and converter
`timescale 1ns/100ps
`default_nettype none
interface qdac_link_if;
  logic sclk;
  logic frame_n;
  logic sdata;
  modport host (output sclk, output frame_n, output sdata);
  modport device (input sclk, input frame_n, input sdata);
endinterface : qdac_link_if
`default_nettype wire

// >>> verilog/qdac_host.sv
// host end: sends one 16-bit frame per request, link clock from divider
`timescale 1ns/100ps
`default_nettype none
module qdac_host (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // request
  input wire logic req_valid,
  input wire logic [1:0] req_addr,
  input wire logic [1:0] req_op,
  input wire logic [11:0] req_code,
  output logic req_ready,
  // serial link
  qdac_link_if.host link
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SETUP = 2'b01,
    ST_SHIFT = 2'b10,
    ST_GAP = 2'b11
  } host_state_e;

  host_state_e state_q;
  logic [15:0] data_q;
  logic [4:0] bits_q;
  logic [3:0] div_q;
  logic sclk_q;
  logic frame_n_q;
  logic sdata_q;
  logic tick;

  assign tick = (div_q == 4'(qdac_pkg::LINK_HALF_CYC - 1));
  assign req_ready = (state_q == ST_IDLE);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) div_q <= 4'h0;
    else if (state_q == ST_IDLE || tick) div_q <= 4'h0;
    else div_q <= div_q + 4'h1;
  end

  // select falls with clock high and one half period before the first fall
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      sclk_q <= 1'b1;
      frame_n_q <= 1'b0;
      sdata_q <= 1'b0;
      data_q <= 16'h0000;
      bits_q <= 5'h00;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          sclk_q <= 1'b1;
          if (req_valid) begin
            data_q <= {req_addr, req_op, req_code};
            frame_n_q <= 1'b1;
            state_q <= ST_SETUP;
          end
        end
        ST_SETUP: if (tick) begin
          frame_n_q <= 1'b0;
          sdata_q <= data_q[15];
          data_q <= {data_q[14:0], 1'b0};
          bits_q <= 5'h00;
          state_q <= ST_SHIFT;
        end
        ST_SHIFT: if (tick) begin
          sclk_q <= ~sclk_q;
          if (!sclk_q) begin
            sdata_q <= data_q[15];
            data_q <= {data_q[14:0], 1'b0};
          end else begin
            bits_q <= bits_q + 5'h01;
            if (bits_q == 5'(qdac_pkg::FRAME_BITS - 1)) state_q <= ST_GAP;
          end
        end
        ST_GAP: if (tick) begin
          // clock returns high with the lines idled low, one half period after the last fall
          sclk_q <= 1'b1;
          frame_n_q <= 1'b0;
          sdata_q <= 1'b0;
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign link.sclk = sclk_q;
  assign link.frame_n = frame_n_q;
  assign link.sdata = sdata_q;
endmodule : qdac_host
`default_nettype wire

// >>> tb/quad_dac_serial_write_control_asserts.sv
// wire-level checks on the serial link between host and converter ends
`timescale 1ns/100ps
`default_nettype none
module quad_dac_serial_write_control_asserts (
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // serial link
  input wire logic sclk,
  input wire logic frame_n,
  input wire logic sdata
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic [4:0] falls_q;
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) falls_q <= 5'h00;
    else if ($fell(frame_n)) falls_q <= 5'h00;
    else if ($fell(sclk) && !frame_n) falls_q <= falls_q + 5'h01;
  end
  sequence frame_start; $fell(frame_n); endsequence
  sequence first_fall; (!$fell(sclk))[*3] ##1 $fell(sclk); endsequence
  a_no_clock_at_select: assert property (frame_start |-> !$fell(sclk))
    else $error("select fell with clock");
  a_select_high_time: assert property (frame_start |-> $past(frame_n, 2))
    else $error("select high too short");
  a_first_bit_setup: assert property (frame_start |-> first_fall)
    else $error("first clock fall misplaced");
  a_sixteen_falls: assert property (frame_start |-> ##[90:100] (falls_q == 5'h10))
    else $error("frame lacks sixteen falls");
  a_no_extra_falls: assert property (falls_q <= 5'h10)
    else $error("more than sixteen falls");
  a_clock_idle_high: assert property (frame_n |-> sclk)
    else $error("clock low outside frame");
  a_data_held_fall: assert property ($fell(sclk) |-> $stable(sdata))
    else $error("data moved at clock fall");
  a_half_period: assert property ($changed(sclk) |=> $stable(sclk)[*2])
    else $error("clock half period short");
  a_idle_lines_low: assert property ($rose(sclk) && falls_q == 5'h10 |-> (!sdata && !frame_n))
    else $error("lines not idled low");
endmodule : quad_dac_serial_write_control_asserts
`default_nettype wire

// >>> tb/quad_dac_serial_write_control_test.sv
// bench: host and converter ends joined, plus a hand-driven second link
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin errors++; \
  $display("MISMATCH %0t value differs", $time); end end
module quad_dac_serial_write_control_test;
  typedef struct packed {
    logic [1:0] addr;
    logic [1:0] op;
    logic [11:0] code;
    logic [47:0] act;
    logic pd;
    logic [1:0] term;
  } row_s;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic req_valid = 1'b0;
  logic [1:0] req_addr = 2'h0;
  logic [1:0] req_op = 2'h0;
  logic [11:0] req_code = 12'h000;
  logic req_ready;
  logic [47:0] active_code;
  logic [47:0] active_code2;
  logic powered_down;
  logic powered_down2;
  logic [1:0] termination;
  logic frame_done;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  row_s rows [9];
  qdac_link_if link ();
  qdac_link_if link2 ();
  qdac_host qdac_host_i (.clk_sys(clk_sys), .resetn(resetn), .req_valid(req_valid),
    .req_addr(req_addr), .req_op(req_op), .req_code(req_code), .req_ready(req_ready), .link(link));
  qdac_device qdac_device_i (.resetn(resetn), .link(link), .active_code(active_code),
    .powered_down(powered_down), .termination(termination), .frame_done(frame_done));
  qdac_device qdac_device_i2 (.resetn(resetn), .link(link2), .active_code(active_code2),
    .powered_down(powered_down2), .termination(), .frame_done());
  quad_dac_serial_write_control_asserts quad_dac_serial_write_control_asserts_i (
    .clk_sys(clk_sys), .resetn(resetn), .sclk(link.sclk), .frame_n(link.frame_n),
    .sdata(link.sdata));
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      wrap_up();
    end
  end
  task wrap_up;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up
  task send(input row_s r);
    int n;
    {req_valid, req_addr, req_op, req_code} = {1'b1, r.addr, r.op, r.code};
    @(posedge clk_sys);
    #1 req_valid = 1'b0;
    n = 0;
    while (req_ready !== 1'b1 && n < 500) begin
      @(posedge clk_sys);
      #1 n++;
    end
    `CHK(active_code, r.act)
    `CHK(powered_down, r.pd)
    `CHK(frame_done, 1'b1)
    if (r.pd) `CHK(termination, r.term)
  endtask : send
  // second link clock runs only inside frames, phase free of clk_sys
  task frame2(input logic [19:0] w, input int n);
    link2.frame_n = 1'b1;
    #30 link2.frame_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      link2.sdata = w[19-i];
      #24 link2.sclk = 1'b0;
      #24 link2.sclk = 1'b1;
    end
    #24 link2.frame_n = 1'b1;
    #30 link2.frame_n = 1'b0;
    link2.sdata = 1'b0;
  endtask : frame2
  initial begin
    {link2.sclk, link2.frame_n, link2.sdata} = 3'h4;
    rows = '{'{2'h1, 2'h0, 12'hABC, 48'h0, 1'h0, 2'h0},
      '{2'h2, 2'h1, 12'h123, 48'h000_123_ABC_000, 1'h0, 2'h0},
      '{2'h0, 2'h2, 12'hFFF, 48'hFFF_FFF_FFF_FFF, 1'h0, 2'h0},
      '{2'h1, 2'h3, 12'h000, 48'hFFF_FFF_FFF_FFF, 1'h1, 2'h1},
      '{2'h2, 2'h3, 12'h000, 48'hFFF_FFF_FFF_FFF, 1'h1, 2'h2},
      '{2'h3, 2'h3, 12'h000, 48'hFFF_FFF_FFF_FFF, 1'h1, 2'h3},
      '{2'h0, 2'h3, 12'h000, 48'hFFF_FFF_FFF_FFF, 1'h1, 2'h0},
      '{2'h3, 2'h0, 12'h000, 48'hFFF_FFF_FFF_FFF, 1'h0, 2'h0},
      '{2'h0, 2'h1, 12'h001, 48'h000_FFF_FFF_001, 1'h0, 2'h0}};
    repeat (10) @(posedge clk_sys);
    #1 resetn = 1'b1;
    `CHK(active_code, 48'h0)
    `CHK(powered_down, 1'b0)
    @(posedge clk_sys);
    #1 foreach (rows[i]) send(rows[i]);
    // aborted power-down frame must leave nothing behind
    frame2(20'hFFFF0, 10);
    `CHK(powered_down2, 1'b0)
    `CHK(active_code2, 48'h0)
    frame2({2'h0, 2'h2, 12'h5A5, 4'hF}, 20);
    `CHK(active_code2, 48'h5A5_5A5_5A5_5A5)
    wrap_up();
  end
endmodule : quad_dac_serial_write_control_test
`default_nettype wire
